// file: src/tlb_pkg.sv
// Operation
// - With kernel_wide_addr, all-ones bits 63:31 decode four 512-Mbyte compatibility segments.
// - compat_kseg_zero unmapped with unmapped_cache_policy; compat_kseg_one unmapped, uncached, blocking.
// - Compat supervisor segment is mapped supervisor space, legal only with supervisor_wide_addr.
// - compat_kseg_three is mapped kernel space, translated through the buffer.
// - Register numbers: slot 0, counter 1, even 2, odd 3, size 5, boundary 6, tag 10.
// - Per-entry page size mask selects which address bits 24:13 are compared.
// - Tag holder: region 63:62, zero fill, page pair 39:13, zeros 12:8, tag 7:0.
// - The 8-bit address_space_tag qualifies each entry match.
// - Entry region is compared with address bits 63:62.
// - Global bit set in both halves makes lookup ignore address_space_tag.
// - Matched page with clear valid bit raises load_miss_exc or store_miss_exc.
// - Page is writable only when its write allow bit is set.
// - Three-bit page cache attribute encodes the eight cacheability modes.
// - Even frame register serves even pages, odd frame register serves odd pages.
// - Slot pointer holds six-bit index used by read_entry_op and indexed_write_op.
// - probe_miss_flag is set when the last probe_op found no match.
// - Replacement counter decrements per retired instruction between boundary and 63.
// - Counter forced to upper bound on reset and on boundary register write.
// - random_write_op writes the entry chosen by the replacement counter.
// - Reserved fields read zero; fill field ignores writes; software writes zeros.
// - Boundary register clears on reset; entries below it escape random writes.
// - Translation exceptions load tag holder with faulting page pair number.
package tlb_pkg;
  localparam int ENTRIES = 64;
  localparam int IDX_W = 6;
  localparam int VPN_W = 27;
  localparam int ADDRESS_SPACE_TAG_W = 8;
  localparam int MASK_W = 12;
  localparam int PFN_W = 24;
  localparam int LO_W = 29;
  localparam int PADDR_W = 36;
  localparam int LO_V_BIT = 0;
  localparam int LO_D_BIT = 1;
  localparam int LO_C_LSB = 2;
  localparam int LO_PFN_LSB = 5;
  localparam int VA_VPN_LSB = 13;
  localparam int VA_REGION_LSB = 62;
  localparam int VA_CSEL_LSB = 29;
  localparam int VA_COMPAT_LSB = 31;
  localparam logic [IDX_W-1:0] RAND_UPPER = 6'h3F;
  localparam logic [IDX_W-1:0] WIRED_RST = 6'h00;
  localparam logic [4:0] REG_SLOT = 5'h00;
  localparam logic [4:0] REG_RAND = 5'h01;
  localparam logic [4:0] REG_EVEN = 5'h02;
  localparam logic [4:0] REG_ODD = 5'h03;
  localparam logic [4:0] REG_PSIZE = 5'h05;
  localparam logic [4:0] REG_WIRED = 5'h06;
  localparam logic [4:0] REG_VTAG = 5'h0A;
  localparam logic [2:0] ATTR_UNC_BLOCK = 3'h2;
  localparam logic [1:0] CSEL_K0 = 2'h0;
  localparam logic [1:0] CSEL_K1 = 2'h1;
  localparam logic [1:0] CSEL_KS = 2'h2;
  typedef enum {SEG_MAPPED, SEG_CK0, SEG_CK1, SEG_CKS, SEG_CK3} tlb_seg_t;
endpackage

// file: src/tlb_match.sv
`timescale 1ns/1ps
module tlb_match (
  input wire logic [1:0] cmp_region,
  input wire logic [tlb_pkg::VPN_W-1:0] cmp_vpn,
  input wire logic [tlb_pkg::ADDRESS_SPACE_TAG_W-1:0] cmp_address_space_tag,
  input wire logic [1:0] ent_region,
  input wire logic [tlb_pkg::VPN_W-1:0] ent_vpn,
  input wire logic [tlb_pkg::ADDRESS_SPACE_TAG_W-1:0] ent_address_space_tag,
  input wire logic [tlb_pkg::MASK_W-1:0] ent_mask,
  input wire logic ent_global,
  output logic hit
);
  import tlb_pkg::*;
  logic vpn_eq;
  // Masked bits are page offset for large pages, so they never take part
  assign vpn_eq = ((cmp_vpn ^ ent_vpn) & ~{15'h0000, ent_mask}) == '0;
  assign hit = (cmp_region == ent_region)
    && vpn_eq
    && (ent_global || cmp_address_space_tag == ent_address_space_tag);
endmodule

// file: src/tlb_ctrl.sv
`timescale 1ns/1ps
module tlb_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic kernel_wide_addr,
  input wire logic supervisor_wide_addr,
  input wire logic [2:0] unmapped_cache_policy,
  input wire logic insn_retire,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [4:0] reg_num,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  input wire logic probe_op,
  input wire logic read_entry_op,
  input wire logic indexed_write_op,
  input wire logic random_write_op,
  input wire logic xlat_req,
  input wire logic [63:0] xlat_vaddr,
  input wire logic xlat_store,
  output logic xlat_done,
  output logic xlat_hit,
  output logic xlat_mapped,
  output logic [tlb_pkg::PADDR_W-1:0] xlat_paddr,
  output logic [2:0] xlat_cache_attr,
  output logic load_miss_exc,
  output logic store_miss_exc,
  output logic mod_exc,
  output logic addr_err_exc
);
  import tlb_pkg::*;

  // Entry storage
  logic [1:0] ent_reg_ff [ENTRIES];
  logic [VPN_W-1:0] ent_vpn_ff [ENTRIES];
  logic [ADDRESS_SPACE_TAG_W-1:0] ent_address_space_tag_ff [ENTRIES];
  logic [MASK_W-1:0] ent_mask_ff [ENTRIES];
  logic ent_g_ff [ENTRIES];
  logic [LO_W-1:0] ent_lo0_ff [ENTRIES];
  logic [LO_W-1:0] ent_lo1_ff [ENTRIES];

  // Staging registers
  logic [IDX_W-1:0] slot_idx_ff;
  logic probe_miss_ff;
  logic [IDX_W-1:0] rand_ff;
  logic [IDX_W-1:0] wired_ff;
  logic [LO_W-1:0] lo0_ff;
  logic [LO_W-1:0] lo1_ff;
  logic lo0_g_ff;
  logic lo1_g_ff;
  logic [MASK_W-1:0] mask_ff;
  logic [1:0] vt_reg_ff;
  logic [VPN_W-1:0] vt_vpn_ff;
  logic [ADDRESS_SPACE_TAG_W-1:0] vt_address_space_tag_ff;
  logic [63:0] reg_rdata_ff;

  logic [ENTRIES-1:0] xl_hit;
  logic [ENTRIES-1:0] pr_hit;
  logic [IDX_W-1:0] xl_idx;
  logic [IDX_W-1:0] pr_idx;
  logic xl_any;
  logic pr_any;
  logic [VPN_W-1:0] va_vpn;
  tlb_seg_t seg;
  logic seg_mapped;
  logic addr_err;
  logic [5:0] odd_sel;
  logic [LO_W-1:0] sel_lo;
  logic [PADDR_W-1:0] ofs_mask;
  logic [PADDR_W-1:0] map_paddr;
  logic page_miss;
  logic page_ro;
  logic xl_exc;
  logic wired_wr;
  logic ent_wr;
  logic [IDX_W-1:0] ent_wr_idx;

  assign va_vpn = xlat_vaddr[VA_VPN_LSB +: VPN_W];
  assign wired_wr = reg_wr_en && reg_num == REG_WIRED;

  // Two comparators per entry: one on the access address, one on the tag holder for probes
  for (genvar gi = 0; gi < ENTRIES; gi++)
  begin : g_ent
    tlb_match u_xl (
      .cmp_region(xlat_vaddr[VA_REGION_LSB +: 2]),
      .cmp_vpn(va_vpn),
      .cmp_address_space_tag(vt_address_space_tag_ff),
      .ent_region(ent_reg_ff[gi]),
      .ent_vpn(ent_vpn_ff[gi]),
      .ent_address_space_tag(ent_address_space_tag_ff[gi]),
      .ent_mask(ent_mask_ff[gi]),
      .ent_global(ent_g_ff[gi]),
      .hit(xl_hit[gi])
    );
    tlb_match u_pr (
      .cmp_region(vt_reg_ff),
      .cmp_vpn(vt_vpn_ff),
      .cmp_address_space_tag(vt_address_space_tag_ff),
      .ent_region(ent_reg_ff[gi]),
      .ent_vpn(ent_vpn_ff[gi]),
      .ent_address_space_tag(ent_address_space_tag_ff[gi]),
      .ent_mask(ent_mask_ff[gi]),
      .ent_global(ent_g_ff[gi]),
      .hit(pr_hit[gi])
    );
  end

  // Multiple matches are a software fault; the lowest index wins, which keeps it deterministic
  always_comb
  begin
    xl_idx = '0;
    pr_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (xl_hit[i])
        xl_idx = IDX_W'(i);
      if (pr_hit[i])
        pr_idx = IDX_W'(i);
    end
  end
  assign xl_any = |xl_hit;
  assign pr_any = |pr_hit;

  // Compatibility segment decode
  always_comb
  begin
    seg = SEG_MAPPED;
    if (kernel_wide_addr && &xlat_vaddr[63:VA_COMPAT_LSB])
    begin
      if (xlat_vaddr[VA_CSEL_LSB +: 2] == CSEL_K0)
        seg = SEG_CK0;
      else if (xlat_vaddr[VA_CSEL_LSB +: 2] == CSEL_K1)
        seg = SEG_CK1;
      else if (xlat_vaddr[VA_CSEL_LSB +: 2] == CSEL_KS)
        seg = SEG_CKS;
      else
        seg = SEG_CK3;
    end
  end
  assign seg_mapped = seg != SEG_CK0 && seg != SEG_CK1;
  assign addr_err = seg == SEG_CKS && !supervisor_wide_addr;

  // Half select: the address bit just above the masked range
  always_comb
  begin
    odd_sel = 6'h0C;
    for (int k = 0; k < MASK_W; k++)
      odd_sel = odd_sel + {5'h00, ent_mask_ff[xl_idx][k]};
  end
  assign sel_lo = xlat_vaddr[odd_sel] ? ent_lo1_ff[xl_idx] : ent_lo0_ff[xl_idx];
  assign ofs_mask = {12'h000, ent_mask_ff[xl_idx], 12'hFFF};
  assign map_paddr = ({sel_lo[LO_PFN_LSB +: PFN_W], 12'h000} & ~ofs_mask) | (xlat_vaddr[PADDR_W-1:0] & ofs_mask);
  assign page_miss = !xl_any || !sel_lo[LO_V_BIT];
  assign page_ro = xlat_store && !sel_lo[LO_D_BIT];
  assign xl_exc = xlat_req && seg_mapped && !addr_err && (page_miss || page_ro);

  // Translation result, one cycle after the request
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      xlat_done <= 1'b0;
      xlat_hit <= 1'b0;
      xlat_mapped <= 1'b0;
      xlat_paddr <= '0;
      xlat_cache_attr <= '0;
      load_miss_exc <= 1'b0;
      store_miss_exc <= 1'b0;
      mod_exc <= 1'b0;
      addr_err_exc <= 1'b0;
    end
    else
    begin
      xlat_done <= xlat_req;
      load_miss_exc <= 1'b0;
      store_miss_exc <= 1'b0;
      mod_exc <= 1'b0;
      addr_err_exc <= 1'b0;
      if (xlat_req)
      begin
        xlat_mapped <= seg_mapped;
        xlat_hit <= seg_mapped && xl_any;
        if (seg == SEG_CK0)
        begin
          xlat_paddr <= {7'h00, xlat_vaddr[28:0]};
          xlat_cache_attr <= unmapped_cache_policy;
        end
        else if (seg == SEG_CK1)
        begin
          xlat_paddr <= {7'h00, xlat_vaddr[28:0]};
          xlat_cache_attr <= ATTR_UNC_BLOCK;
        end
        else
        begin
          xlat_paddr <= map_paddr;
          xlat_cache_attr <= sel_lo[LO_C_LSB +: 3];
          addr_err_exc <= addr_err;
          load_miss_exc <= !addr_err && page_miss && !xlat_store;
          store_miss_exc <= !addr_err && page_miss && xlat_store;
          mod_exc <= !addr_err && !page_miss && page_ro;
        end
      end
    end
  end

  // Slot pointer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      slot_idx_ff <= '0;
      probe_miss_ff <= 1'b0;
    end
    else if (probe_op)
    begin
      probe_miss_ff <= !pr_any;
      if (pr_any)
        slot_idx_ff <= pr_idx;
    end
    else if (reg_wr_en && reg_num == REG_SLOT)
      slot_idx_ff <= reg_wdata[IDX_W-1:0];
  end

  // Boundary and replacement counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wired_ff <= WIRED_RST;
    else if (wired_wr)
      wired_ff <= reg_wdata[IDX_W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rand_ff <= RAND_UPPER;
    else if (wired_wr)
      rand_ff <= RAND_UPPER;
    else if (insn_retire)
      rand_ff <= (rand_ff <= wired_ff) ? RAND_UPPER : rand_ff - 6'h01;
  end

  // Frame and page size staging
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      lo0_ff <= '0;
      lo1_ff <= '0;
      lo0_g_ff <= 1'b0;
      lo1_g_ff <= 1'b0;
      mask_ff <= '0;
    end
    else if (read_entry_op)
    begin
      lo0_ff <= ent_lo0_ff[slot_idx_ff];
      lo1_ff <= ent_lo1_ff[slot_idx_ff];
      lo0_g_ff <= ent_g_ff[slot_idx_ff];
      lo1_g_ff <= ent_g_ff[slot_idx_ff];
      mask_ff <= ent_mask_ff[slot_idx_ff];
    end
    else if (reg_wr_en)
    begin
      if (reg_num == REG_EVEN)
      begin
        lo0_ff <= reg_wdata[LO_W:1];
        lo0_g_ff <= reg_wdata[0];
      end
      else if (reg_num == REG_ODD)
      begin
        lo1_ff <= reg_wdata[LO_W:1];
        lo1_g_ff <= reg_wdata[0];
      end
      else if (reg_num == REG_PSIZE)
        mask_ff <= reg_wdata[VA_VPN_LSB +: MASK_W];
    end
  end

  // Virtual tag holder; a faulting access outranks software so the handler sees the fault
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      vt_reg_ff <= '0;
      vt_vpn_ff <= '0;
      vt_address_space_tag_ff <= '0;
    end
    else if (xl_exc)
    begin
      vt_reg_ff <= xlat_vaddr[VA_REGION_LSB +: 2];
      vt_vpn_ff <= va_vpn;
    end
    else if (read_entry_op)
    begin
      vt_reg_ff <= ent_reg_ff[slot_idx_ff];
      vt_vpn_ff <= ent_vpn_ff[slot_idx_ff];
      vt_address_space_tag_ff <= ent_address_space_tag_ff[slot_idx_ff];
    end
    else if (reg_wr_en && reg_num == REG_VTAG)
    begin
      vt_reg_ff <= reg_wdata[63:62];
      vt_vpn_ff <= reg_wdata[39:13];
      vt_address_space_tag_ff <= reg_wdata[7:0];
    end
  end

  // Entry writes
  assign ent_wr = indexed_write_op || random_write_op;
  assign ent_wr_idx = indexed_write_op ? slot_idx_ff : rand_ff;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      for (int e = 0; e < ENTRIES; e++)
      begin
        ent_lo0_ff[e] <= '0;
        ent_lo1_ff[e] <= '0;
        ent_g_ff[e] <= 1'b0;
        ent_reg_ff[e] <= '0;
        ent_vpn_ff[e] <= '0;
        ent_address_space_tag_ff[e] <= '0;
        ent_mask_ff[e] <= '0;
      end
    end
    else if (ent_wr)
    begin
      ent_lo0_ff[ent_wr_idx] <= lo0_ff;
      ent_lo1_ff[ent_wr_idx] <= lo1_ff;
      ent_g_ff[ent_wr_idx] <= lo0_g_ff && lo1_g_ff;
      ent_reg_ff[ent_wr_idx] <= vt_reg_ff;
      ent_vpn_ff[ent_wr_idx] <= vt_vpn_ff;
      ent_address_space_tag_ff[ent_wr_idx] <= vt_address_space_tag_ff;
      ent_mask_ff[ent_wr_idx] <= mask_ff;
    end
  end

  // Register read port, data one cycle after the strobe; unknown numbers read zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata_ff <= '0;
    else if (reg_rd_en)
    begin
      if (reg_num == REG_SLOT)
        reg_rdata_ff <= {32'h00000000, probe_miss_ff, 25'h0000000, slot_idx_ff};
      else if (reg_num == REG_RAND)
        reg_rdata_ff <= {58'h0, rand_ff};
      else if (reg_num == REG_EVEN)
        reg_rdata_ff <= {34'h0, lo0_ff, lo0_g_ff};
      else if (reg_num == REG_ODD)
        reg_rdata_ff <= {34'h0, lo1_ff, lo1_g_ff};
      else if (reg_num == REG_PSIZE)
        reg_rdata_ff <= {39'h0, mask_ff, 13'h0000};
      else if (reg_num == REG_WIRED)
        reg_rdata_ff <= {58'h0, wired_ff};
      else if (reg_num == REG_VTAG)
        reg_rdata_ff <= {vt_reg_ff, 22'h000000, vt_vpn_ff, 5'h00, vt_address_space_tag_ff};
      else
        reg_rdata_ff <= '0;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wired_wr;
    wired_wr;
  endsequence
  sequence s_dec_step;
    insn_retire && !wired_wr && rand_ff > wired_ff;
  endsequence
  sequence s_bad_valid;
    xlat_req && !xlat_store && seg_mapped && !addr_err && xl_any && !sel_lo[LO_V_BIT];
  endsequence

  random_bound_a: assert property (rand_ff >= wired_ff)
    else $error("replacement counter below boundary");
  wired_force_a: assert property (s_wired_wr |=> rand_ff == RAND_UPPER)
    else $error("counter not forced to upper bound");
  random_dec_a: assert property (s_dec_step |=> rand_ff == $past(rand_ff) - 6'h01)
    else $error("counter did not decrement");
  probe_miss_a: assert property (probe_op && !pr_any |=> probe_miss_ff)
    else $error("probe miss flag not set");
  probe_hit_a: assert property (probe_op && pr_any |=> !probe_miss_ff && slot_idx_ff == $past(pr_idx))
    else $error("probe hit index wrong");
  kseg1_attr_a: assert property (xlat_req && seg == SEG_CK1 |=> xlat_done && !xlat_mapped
    && xlat_cache_attr == ATTR_UNC_BLOCK)
    else $error("uncached segment attribute wrong");
  invalid_exc_a: assert property (s_bad_valid |=> load_miss_exc && !store_miss_exc)
    else $error("invalid page did not raise load miss");
  vtag_load_a: assert property (xl_exc |=> vt_vpn_ff == $past(va_vpn))
    else $error("tag holder not loaded on fault");
  ksseg_err_a: assert property (xlat_req && seg == SEG_CKS && !supervisor_wide_addr |=> addr_err_exc)
    else $error("supervisor segment not refused");
endmodule

// file: testbench/tlb_pipe_model.sv
`timescale 1ns/1ps
module tlb_pipe_model (
  input wire logic core_clk,
  output logic insn_retire
);
  initial insn_retire = 1'b0;
  // Retire pulses launched on the falling edge, one per cycle, so none straddles a sampling edge
  task automatic retire(input int n);
    repeat (n)
    begin
      insn_retire = 1'b1;
      @(negedge core_clk);
    end
    insn_retire = 1'b0;
  endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import tlb_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic kwa = 1'b1;
  logic swa = 1'b0;
  logic [2:0] ucp = 3'h5;
  logic insn_retire;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [4:0] reg_num = 5'h00;
  logic [63:0] reg_wdata = 64'h0;
  logic [63:0] reg_rdata;
  logic [3:0] ops = 4'h0;
  logic xlat_req = 1'b0;
  logic [63:0] xlat_vaddr = 64'h0;
  logic xlat_store = 1'b0;
  logic xlat_done, xlat_hit, xlat_mapped, lme, sme, mde, aee;
  logic [PADDR_W-1:0] xlat_paddr;
  logic [2:0] xlat_cache_attr;
  int n_fail = 0;
  int checks = 0;
  // Tag value with set fill bits; only region, pair and tag survive
  localparam logic [63:0] TAGV = 64'hFFFFFFFFE0004003;
  localparam logic [63:0] TAGR = 64'hC00000FFE0004003;
  localparam logic [63:0] EVEN = 64'h48DE;
  localparam logic [63:0] ODD = 64'h11592;

  tlb_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .kernel_wide_addr(kwa), .supervisor_wide_addr(swa),
    .unmapped_cache_policy(ucp), .insn_retire(insn_retire), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .probe_op(ops[0]),
    .read_entry_op(ops[1]), .indexed_write_op(ops[2]), .random_write_op(ops[3]), .xlat_req(xlat_req),
    .xlat_vaddr(xlat_vaddr), .xlat_store(xlat_store), .xlat_done(xlat_done), .xlat_hit(xlat_hit),
    .xlat_mapped(xlat_mapped), .xlat_paddr(xlat_paddr), .xlat_cache_attr(xlat_cache_attr),
    .load_miss_exc(lme), .store_miss_exc(sme), .mod_exc(mde), .addr_err_exc(aee));
  tlb_pipe_model pipe (.core_clk(core_clk), .insn_retire(insn_retire));

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic summarize;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp=%h got=%h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] n, input logic [63:0] d);
    reg_wr_en = 1'b1;
    reg_num = n;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    // Idle cycle so a following call never re-raises the strobe in the same step
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [4:0] n, input logic [63:0] exp);
    reg_rd_en = 1'b1;
    reg_num = n;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk($sformatf("reg%0d", n), reg_rdata, exp);
    @(negedge core_clk);
  endtask

  task automatic op(input int i);
    ops[i] = 1'b1;
    @(negedge core_clk);
    ops = 4'h0;
    @(negedge core_clk);
  endtask

  // Outcome vector: hit, load miss, store miss, modify, address error
  task automatic xl(input logic [63:0] va, input logic st, input logic mp, input logic [35:0] pa,
                    input logic [2:0] at, input logic [4:0] ex);
    xlat_req = 1'b1;
    xlat_vaddr = va;
    xlat_store = st;
    @(negedge core_clk);
    xlat_req = 1'b0;
    chk("done", 64'(xlat_done), 64'h1);
    chk("exc", 64'({xlat_hit, lme, sme, mde, aee}), 64'(ex));
    if (ex[3:1] == 3'h0 && ex[0] == 1'b0)
    begin
      chk("mapped", 64'(xlat_mapped), 64'(mp));
      chk("paddr", 64'(xlat_paddr), 64'(pa));
      chk("attr", 64'(xlat_cache_attr), 64'(at));
    end
    @(negedge core_clk);
  endtask

  task automatic t_reset_regs;
    rd(REG_RAND, 64'h3F);
    rd(REG_WIRED, 64'h0);
    rd(REG_SLOT, 64'h0);
    rd(5'h04, 64'h0);
  endtask

  task automatic t_fields;
    wr(REG_VTAG, TAGV);
    rd(REG_VTAG, TAGR);
    wr(REG_EVEN, 64'hFFFFFFFFFFFFFFFF);
    rd(REG_EVEN, 64'h3FFFFFFF);
    // A 4-Mbyte page size pattern only
    wr(REG_PSIZE, 64'h7FE000);
    rd(REG_PSIZE, 64'h7FE000);
    wr(REG_PSIZE, 64'h0);
    wr(REG_RAND, 64'h0);
    rd(REG_RAND, 64'h3F);
  endtask

  task automatic t_random_write;
    wr(REG_EVEN, 64'h0);
    wr(REG_VTAG, 64'hFFFFFFFFE0010003);
    op(3);
    wr(REG_VTAG, 64'h0);
    wr(REG_SLOT, 64'h3F);
    op(1);
    rd(REG_VTAG, 64'hC00000FFE0010003);
  endtask

  task automatic t_probe_xlat;
    wr(REG_VTAG, TAGV);
    wr(REG_EVEN, EVEN);
    wr(REG_ODD, ODD);
    wr(REG_PSIZE, 64'h0);
    wr(REG_SLOT, 64'h7);
    op(2);
    wr(REG_SLOT, 64'h0);
    op(0);
    rd(REG_SLOT, 64'h7);
    xl(64'hFFFFFFFFE0004010, 1'b0, 1'b1, 36'h123010, 3'h3, 5'h10);
    xl(64'hFFFFFFFFE0005010, 1'b0, 1'b1, 36'h456010, 3'h2, 5'h10);
    xl(64'hFFFFFFFFE0004020, 1'b1, 1'b1, 36'h123020, 3'h3, 5'h10);
    xl(64'hFFFFFFFFE0005010, 1'b1, 1'b1, 36'h0, 3'h0, 5'h12);
    // Entry 63 matches but both halves are invalid
    xl(64'hFFFFFFFFE0010000, 1'b0, 1'b1, 36'h0, 3'h0, 5'h18);
    xl(64'hFFFFFFFFE0008010, 1'b0, 1'b1, 36'h0, 3'h0, 5'h08);
    rd(REG_VTAG, 64'hC00000FFE0008003);
    wr(REG_VTAG, TAGV + 64'h1);
    op(0);
    rd(REG_SLOT, 64'h80000007);
    xl(64'hFFFFFFFFE0004010, 1'b1, 1'b1, 36'h0, 3'h0, 5'h04);
  endtask

  // 16-Kbyte global entry: bit 14 picks the half, bits 13:0 are offset
  task automatic t_large_page;
    wr(REG_VTAG, 64'hFFFFFFFFE0400004);
    wr(REG_EVEN, EVEN | 64'h1);
    wr(REG_ODD, ODD | 64'h1);
    wr(REG_PSIZE, 64'h6000);
    wr(REG_SLOT, 64'h9);
    op(2);
    wr(REG_VTAG, 64'hFFFFFFFFE0400005);
    xl(64'hFFFFFFFFE0407010, 1'b0, 1'b1, 36'h457010, 3'h2, 5'h10);
    xl(64'hFFFFFFFFE0403020, 1'b0, 1'b1, 36'h123020, 3'h3, 5'h10);
    op(1);
    rd(REG_EVEN, EVEN | 64'h1);
    rd(REG_PSIZE, 64'h6000);
  endtask

  task automatic t_compat;
    xl(64'hFFFFFFFF80000123, 1'b0, 1'b0, 36'h123, 3'h5, 5'h00);
    ucp = 3'h3;
    xl(64'hFFFFFFFF80000123, 1'b0, 1'b0, 36'h123, 3'h3, 5'h00);
    xl(64'hFFFFFFFFA0000010, 1'b0, 1'b0, 36'h10, ATTR_UNC_BLOCK, 5'h00);
    xl(64'hFFFFFFFFC0000000, 1'b0, 1'b0, 36'h0, 3'h0, 5'h01);
    swa = 1'b1;
    xl(64'hFFFFFFFFC0000000, 1'b0, 1'b1, 36'h0, 3'h0, 5'h08);
    // Without wide kernel addressing the same address is looked up as mapped space
    kwa = 1'b0;
    xl(64'hFFFFFFFF80000123, 1'b0, 1'b1, 36'h0, 3'h0, 5'h08);
    kwa = 1'b1;
  endtask

  task automatic t_counter;
    wr(REG_WIRED, 64'h5);
    rd(REG_RAND, 64'h3F);
    pipe.retire(58);
    rd(REG_RAND, 64'h5);
    pipe.retire(1);
    rd(REG_RAND, 64'h3F);
  endtask

  initial
  begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset_regs();
    t_fields();
    t_random_write();
    t_probe_xlat();
    t_large_page();
    t_compat();
    t_counter();
    summarize();
  end

  // Watchdog in case a task never returns
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    summarize();
  end
endmodule
